/* flash_regs_pkg.sv */
// Constants for the flash status and configuration register set
// ==========================================================
// Overview of operation
// - Lock bit with WP low blocks register writes
// - Program error flag set on program failure
// - Erase error flag set on erase failure
// - Three guard bits select protected sector range
// - Writes, program, erase need write-enable latch set
// - Only enable/disable commands change the latch
// - Busy bit high while any operation runs
// - Config bits 7:6 select read latency code
// - Origin bit: 1 low end, 0 high end
// - Config bit 3 makes guard bits volatile
// - Parameter sectors top when bit set, else bottom
// - Config bit 1 selects quad I/O mode
// - Freeze bit locks guard, origin, location bits
// - Status two bit 1 shows erase suspended
// - Status two bit 0 shows program suspended
package flash_regs_pkg;

    // ==========================================================
    // Status register one layout
    localparam int STAT1_LOCK = 7;
    localparam int STAT1_PERR = 6;
    localparam int STAT1_EERR = 5;
    localparam int STAT1_GUARD_HI = 4;
    localparam int STAT1_GUARD_LO = 2;
    localparam int STAT1_LATCH = 1;
    localparam int STAT1_BUSY = 0;

    // ==========================================================
    // Configuration register layout
    localparam int CFG_LAT_HI = 7;
    localparam int CFG_LAT_LO = 6;
    localparam int CFG_ORIGIN = 5;
    localparam int CFG_VOLATILE = 3;
    localparam int CFG_PARAM_LOC = 2;
    localparam int CFG_QUAD = 1;
    localparam int CFG_FREEZE = 0;
    // One-time bits may only go from 0 to 1
    localparam logic [7:0] CFG_OTP_MASK = 8'h2c;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ==========================================================
    // Status register two layout
    localparam int STAT2_ERASE_SUSP = 1;
    localparam int STAT2_PROG_SUSP = 0;
    localparam logic [5:0] STAT2_RSVD = 6'h00;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int REGWR_BUSY_NS = 200;
    localparam int REGWR_BUSY_CYCLES =
        (REGWR_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W = $clog2(REGWR_BUSY_CYCLES + 1);

endpackage

/* flash_status_config_regs.sv */
// Serial-link register set: status one, configuration, status two
`timescale 1ns/100ps

module flash_status_config_regs
    import flash_regs_pkg::*;
#(
    parameter logic [7:0] OP_WRITE_REGS = 8'h01,
    parameter logic [7:0] OP_WRITE_ENABLE = 8'h06,
    parameter logic [7:0] OP_WRITE_DISABLE = 8'h04,
    parameter logic [7:0] OP_READ_STAT1 = 8'h05,
    parameter logic [7:0] OP_READ_STAT2 = 8'h07,
    parameter logic [7:0] OP_READ_CFG = 8'h35,
    parameter logic [7:0] OP_PROGRAM = 8'h02,
    parameter logic [7:0] OP_ERASE = 8'hd8
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    output logic SO,
    output logic SO_OE,
    input wire logic WP_N,
    input wire logic ARRAY_BUSY,
    input wire logic PROG_ERR_EV,
    input wire logic ERASE_ERR_EV,
    input wire logic ERASE_SUSPENDED,
    input wire logic PROGRAM_SUSPENDED,
    output logic PROG_GO,
    output logic ERASE_GO,
    output logic [2:0] GUARD_BITS,
    output logic PROTECT_ORIGIN_LOW,
    output logic GUARD_VOLATILE,
    output logic PARAM_AT_TOP,
    output logic QUAD_MODE,
    output logic [1:0] LATENCY_CODE,
    output logic FREEZE
);

    typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA, PH_READ} phase_t;

    typedef struct packed {
        logic [2:0] sck_p;
        logic [2:0] csn_p;
        logic [1:0] si_p;
        logic [1:0] wp_p;
        phase_t phase;
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] opcode;
        logic [7:0] data1;
        logic [7:0] data2;
        logic [7:0] tx;
        logic [2:0] out_cnt;
        logic so;
        logic so_oe;
        logic lock;
        logic [2:0] guard;
        logic latch;
        logic perr;
        logic eerr;
        logic [7:0] cfg;
        logic [BUSY_W-1:0] busy_cnt;
        logic prog_go;
        logic erase_go;
    } state_t;

    state_t q;
    state_t d;

    // ==========================================================
    // Link edge detection, read only past the second flop
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic cs_active;
    logic wp_low;
    logic busy;
    logic frame_ok;
    logic regwr_try;
    logic regwr_go;
    logic [7:0] stat1;
    logic [7:0] stat2;

    assign sck_rise = q.sck_p[1] & ~q.sck_p[2];
    assign sck_fall = ~q.sck_p[1] & q.sck_p[2];
    assign cs_fall = ~q.csn_p[1] & q.csn_p[2];
    assign cs_rise = q.csn_p[1] & ~q.csn_p[2];
    assign cs_active = ~q.csn_p[1];
    assign wp_low = ~q.wp_p[1];

    // Busy from write timer or array
    assign busy = (q.busy_cnt != '0) | ARRAY_BUSY;

    // Commands run only on whole bytes, at frame end, when idle
    assign frame_ok = cs_rise & (q.phase == PH_DATA)
        & (q.bit_cnt == 3'h0) & ~busy;
    assign regwr_try = frame_ok & (q.opcode == OP_WRITE_REGS)
        & (q.byte_cnt != 2'h0) & q.latch;
    // Lock with WP low refuses writes
    assign regwr_go = regwr_try & ~(q.lock & wp_low);

    assign stat1 = {q.lock, q.perr, q.eerr, q.guard, q.latch, busy};
    assign stat2 = {STAT2_RSVD, ERASE_SUSPENDED, PROGRAM_SUSPENDED};

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] byte_in;
        logic [7:0] word;
        logic [7:0] sel;
        byte_in = {q.shift[6:0], q.si_p[1]};
        word = 8'h00;
        sel = 8'h00;
        d = q;
        d.sck_p = {q.sck_p[1:0], SCK};
        d.csn_p = {q.csn_p[1:0], CS_N};
        d.si_p = {q.si_p[0], SI};
        d.wp_p = {q.wp_p[0], WP_N};
        d.prog_go = 1'b0;
        d.erase_go = 1'b0;

        if (q.opcode == OP_READ_STAT1) begin
            sel = stat1;
        end else if (q.opcode == OP_READ_STAT2) begin
            sel = stat2;
        end else if (q.opcode == OP_READ_CFG) begin
            sel = q.cfg;
        end

        if (q.busy_cnt != '0) begin
            d.busy_cnt = q.busy_cnt - 1'b1;
        end
        if (PROG_ERR_EV) begin
            d.perr = 1'b1;
        end
        if (ERASE_ERR_EV) begin
            d.eerr = 1'b1;
        end

        if (cs_fall) begin
            d.phase = PH_CMD;
            d.bit_cnt = 3'h0;
            d.byte_cnt = 2'h0;
            d.so_oe = 1'b0;
        end else if (cs_active && sck_rise && q.phase != PH_IDLE) begin
            d.shift = byte_in;
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == 3'h7) begin
                case (q.phase)
                    PH_CMD: begin
                        d.opcode = byte_in;
                        d.out_cnt = 3'h0;
                        if (byte_in == OP_READ_STAT1
                                || byte_in == OP_READ_STAT2
                                || byte_in == OP_READ_CFG) begin
                            d.phase = PH_READ;
                        end else begin
                            d.phase = PH_DATA;
                        end
                    end
                    PH_DATA: begin
                        if (q.byte_cnt == 2'h0) begin
                            d.data1 = byte_in;
                        end
                        if (q.byte_cnt == 2'h1) begin
                            d.data2 = byte_in;
                        end
                        if (q.byte_cnt != 2'h3) begin
                            d.byte_cnt = q.byte_cnt + 2'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (cs_active && sck_fall && q.phase == PH_READ) begin
            // Fresh snapshot each byte so polling sees busy drop
            word = (q.out_cnt == 3'h0) ? sel : q.tx;
            d.so = word[7];
            d.tx = {word[6:0], 1'b0};
            d.out_cnt = q.out_cnt + 3'h1;
            d.so_oe = 1'b1;
        end

        if (cs_rise) begin
            d.phase = PH_IDLE;
            d.so_oe = 1'b0;
            // Latch moved by enable and disable only
            if (frame_ok && q.byte_cnt == 2'h0) begin
                if (q.opcode == OP_WRITE_ENABLE) begin
                    d.latch = 1'b1;
                end else if (q.opcode == OP_WRITE_DISABLE) begin
                    d.latch = 1'b0;
                end
            end
            // Program and erase gated by latch
            if (frame_ok && q.latch && q.opcode == OP_PROGRAM) begin
                d.prog_go = 1'b1;
            end
            if (frame_ok && q.latch && q.opcode == OP_ERASE) begin
                d.erase_go = 1'b1;
            end
            if (regwr_go) begin
                d.lock = q.data1[STAT1_LOCK];
                if (!q.cfg[CFG_FREEZE]) begin
                    d.guard = q.data1[STAT1_GUARD_HI:STAT1_GUARD_LO];
                end
                if (q.byte_cnt != 2'h1) begin
                    d.cfg[CFG_LAT_HI:CFG_LAT_LO] =
                        q.data2[CFG_LAT_HI:CFG_LAT_LO];
                    d.cfg[CFG_QUAD] = q.data2[CFG_QUAD];
                    // Freeze clears only at reset
                    d.cfg[CFG_FREEZE] = q.cfg[CFG_FREEZE]
                        | q.data2[CFG_FREEZE];
                    d.cfg[CFG_VOLATILE] = q.cfg[CFG_VOLATILE]
                        | q.data2[CFG_VOLATILE];
                    if (!q.cfg[CFG_FREEZE]) begin
                        d.cfg[CFG_ORIGIN] = q.cfg[CFG_ORIGIN]
                            | q.data2[CFG_ORIGIN];
                        d.cfg[CFG_PARAM_LOC] = q.cfg[CFG_PARAM_LOC]
                            | q.data2[CFG_PARAM_LOC];
                    end
                end
                d.busy_cnt = BUSY_W'(REGWR_BUSY_CYCLES);
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            q <= '0;
            q.csn_p <= 3'h7;
            q.sck_p <= 3'h0;
            q.cfg <= CFG_RESET;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign SO = q.so;
    assign SO_OE = q.so_oe;
    assign PROG_GO = q.prog_go;
    assign ERASE_GO = q.erase_go;
    assign GUARD_BITS = q.guard;
    assign PROTECT_ORIGIN_LOW = q.cfg[CFG_ORIGIN];
    assign GUARD_VOLATILE = q.cfg[CFG_VOLATILE];
    assign PARAM_AT_TOP = q.cfg[CFG_PARAM_LOC];
    assign QUAD_MODE = q.cfg[CFG_QUAD];
    assign LATENCY_CODE = q.cfg[CFG_LAT_HI:CFG_LAT_LO];
    assign FREEZE = q.cfg[CFG_FREEZE];

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_lock_blocks_write: assert property (
        regwr_try && q.lock && wp_low |=> $stable(q.cfg) && $stable(q.lock)
            && $stable(q.guard))
        else $error("register write taken while locked");

    a_prog_err_set: assert property (
        PROG_ERR_EV |=> q.perr[*3])
        else $error("program error flag not set");

    a_erase_err_set: assert property (
        ERASE_ERR_EV |=> q.eerr ##1 q.eerr)
        else $error("erase error flag not set");

    a_go_needs_latch: assert property (
        PROG_GO || ERASE_GO |-> $past(q.latch))
        else $error("program or erase started without latch");

    a_latch_only_cmds: assert property (
        $changed(q.latch) |-> $past(cs_rise && (q.opcode == OP_WRITE_ENABLE
            || q.opcode == OP_WRITE_DISABLE)))
        else $error("latch moved by another command");

    a_write_busy: assert property (
        regwr_go |=> stat1[STAT1_BUSY][*8])
        else $error("busy not held after register write");

    a_freeze_guard: assert property (
        q.cfg[CFG_FREEZE] |=> $stable(GUARD_BITS)
            && $stable(PROTECT_ORIGIN_LOW) && $stable(PARAM_AT_TOP))
        else $error("frozen bits changed");

    a_write_updates: assert property (
        regwr_go && !q.cfg[CFG_FREEZE] |=> GUARD_BITS ==
            $past(q.data1[STAT1_GUARD_HI:STAT1_GUARD_LO]))
        else $error("accepted write did not update guard bits");

endmodule

/* spi_host.sv */
// Behavioural serial host that drives the register link
`timescale 1ns/100ps
module spi_host (
    output logic sck,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end

    // ==========================================================
    // Frames
    // Mode 0, msb first, 125 ns link clock; rx keeps the last byte
    task automatic frame(input logic [7:0] b0, b1, b2, input int n,
                         output logic [7:0] rx);
        logic [23:0] tx;
        tx = {b0, b1, b2};
        rx = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < 8 * n; i++) begin
            si = tx[23 - i];
            #62.5 sck = 1'b1;
            rx = {rx[6:0], so};
            #62.5 sck = 1'b0;
        end
        #62.5 cs_n = 1'b1;
        // Released line must not keep a stale level
        si = ~si;
        #250;
    endtask

    task automatic wr(input logic [7:0] b0, b1, b2, input int n);
        logic [7:0] r;
        frame(b0, b1, b2, n, r);
        for (int k = 0; k < 20; k++) begin
            frame(8'h05, 8'h00, 8'h00, 2, r);
            if (r[0] === 1'b0)
                break;
        end
    endtask
endmodule

/* flash_status_config_regs_tb.sv */
// Self-checking bench for the flash status and config registers
`timescale 1ns/100ps
module flash_status_config_regs_tb;
    import flash_regs_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, wp_n = 1'b1, abusy = 1'b0;
    logic perr = 1'b0, eerr = 1'b0, esusp = 1'b0, psusp = 1'b0;
    logic sck, cs_n, si, so, so_oe, pgo, ego, org, vol, ptop, quad, frz;
    logic [2:0] guard;
    logic [1:0] lat;
    logic [7:0] cfg_out, r;
    logic so_pin;
    int n_fail = 0, compares = 0, n_prog = 0, n_erase = 0;
    assign cfg_out = {lat, org, 1'b0, vol, ptop, quad, frz};

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (pgo === 1'b1) n_prog++;
        if (ego === 1'b1) n_erase++;
    end

    // Undriven pin reads inverted, so a late output enable shows up
    assign so_pin = so_oe ? so : ~so;
    spi_host host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_pin));
    flash_status_config_regs dut (.CLK(clk), .RESETN(resetn),
        .SCK(sck), .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe),
        .WP_N(wp_n), .ARRAY_BUSY(abusy), .PROG_ERR_EV(perr),
        .ERASE_ERR_EV(eerr), .ERASE_SUSPENDED(esusp),
        .PROGRAM_SUSPENDED(psusp), .PROG_GO(pgo), .ERASE_GO(ego),
        .GUARD_BITS(guard), .PROTECT_ORIGIN_LOW(org),
        .GUARD_VOLATILE(vol), .PARAM_AT_TOP(ptop), .QUAD_MODE(quad),
        .LATENCY_CODE(lat), .FREEZE(frz));

    // ==========================================================
    // Helpers
    task automatic chk(input logic [7:0] g, e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] op);
        host.frame(op, 8'h00, 8'h00, 2, r);
    endtask
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd(8'h05);
        chk(r, 8'h00);
        rd(8'h35);
        chk(r, CFG_RESET);
        rd(8'h07);
        chk(r, 8'h00);
        $display("reset values done");
    endtask
    task automatic t_latch;
        host.wr(8'h06, 8'h00, 8'h00, 1);
        rd(8'h05);
        chk(r, 8'h02);
        host.wr(8'h04, 8'h00, 8'h00, 1);
        rd(8'h05);
        chk(r, 8'h00);
        host.wr(8'h01, 8'h1c, 8'hc2, 3);
        chk({5'h00, guard}, 8'h00);
        chk(cfg_out, 8'h00);
        host.wr(8'h02, 8'h00, 8'h00, 1);
        chk(n_prog[7:0], 8'h00);
        $display("latch gating done");
    endtask
    task automatic t_write;
        host.wr(8'h06, 8'h00, 8'h00, 1);
        host.wr(8'h01, 8'h1c, 8'hc2, 3);
        chk({5'h00, guard}, 8'h07);
        chk(cfg_out, 8'hc2);
        rd(8'h05);
        chk(r, 8'h1e);
        host.wr(8'h02, 8'h00, 8'h00, 1);
        host.wr(8'hd8, 8'h00, 8'h00, 1);
        chk({n_prog[3:0], n_erase[3:0]}, 8'h11);
        rd(8'h05);
        chk(r, 8'h1e);
        @(negedge clk) abusy = 1'b1;
        rd(8'h05);
        chk(r, 8'h1f);
        host.frame(8'h01, 8'h00, 8'h00, 3, r);
        chk({5'h00, guard}, 8'h07);
        @(negedge clk) abusy = 1'b0;
        $display("register write done");
    endtask
    task automatic t_lock;
        host.wr(8'h01, 8'h9c, 8'hc2, 3);
        @(negedge clk) wp_n = 1'b0;
        host.wr(8'h01, 8'h00, 8'h00, 3);
        chk({guard, 5'h00}, 8'he0);
        chk(cfg_out, 8'hc2);
        @(negedge clk) wp_n = 1'b1;
        host.wr(8'h01, 8'h00, 8'h00, 3);
        rd(8'h05);
        chk(r, 8'h02);
        $display("lock done");
    endtask
    task automatic t_otp;
        host.wr(8'h01, 8'h00, 8'h2d, 3);
        chk(cfg_out, 8'h2d);
        host.wr(8'h01, 8'h1c, 8'h01, 3);
        chk({5'h00, guard}, 8'h00);
        rd(8'h35);
        chk(r, 8'h2d);
        $display("one-time and freeze done");
    endtask
    task automatic t_status;
        @(negedge clk) esusp = 1'b1;
        rd(8'h07);
        chk(r, 8'h02);
        @(negedge clk) {esusp, psusp} = 2'b01;
        rd(8'h07);
        chk(r, 8'h01);
        @(negedge clk) {perr, eerr} = 2'b11;
        @(negedge clk) {perr, eerr} = 2'b00;
        rd(8'h05);
        chk(r, 8'h62);
        $display("status flags done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk) resetn = 1'b1;
        repeat (4) @(negedge clk);
        t_reset;
        t_latch;
        t_write;
        t_lock;
        t_otp;
        t_status;
        conclude;
    end
    // Tests take about 100 us; allow two and a half times that
    initial begin
        #250000;
        n_fail++;
        conclude;
    end
endmodule
